// ==== src/async_serial_transmitter.sv ====
// asynchronous serial transmitter with wishbone register access
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "async_tx_defines.svh"

module async_serial_transmitter
  import async_tx_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // transmit pin
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe_out,
  // receive pin
  input wire logic rx_pin_in,
  output logic rx_pin_out,
  output logic rx_pin_oe_out,
  // interrupt request
  output logic tx_int_req_out
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] read_mux(input tx_state_t s, input logic [7:0] adr,
                                          input logic tx_lvl, input logic rx_lvl);
    logic [7:0] r;
    r = 8'h00;
    unique case (adr)
      `ADR_TX_STATUS_CONTROL:
      begin
        r[`TX_STATUS_CONTROL_CSRC] = s.csrc;
        r[`TX_STATUS_CONTROL_NINE_SEL] = s.nine_sel;
        r[`TX_STATUS_CONTROL_TRANSMIT_ENABLE_BIT] = s.transmit_enable_bit;
        r[`TX_STATUS_CONTROL_SYNC] = s.sync;
        r[`TX_STATUS_CONTROL_HIGH_BAUD_SELECT] = s.high_baud_select;
        r[`TX_STATUS_CONTROL_SHIFT_EMPTY_STATUS] = s.shift_empty_status;
        r[`TX_STATUS_CONTROL_NINTH] = s.ninth;
      end
      `ADR_RX_STATUS_CONTROL: r[7:`RX_STATUS_CONTROL_CTL_LSB] = s.rx_status_control_ctl;
      `ADR_BAUD_DIVISOR: r = s.divisor;
      `ADR_PERIPH_INT_FLAGS: r[`PIR_TX_BUFFER_EMPTY_FLAG] = s.tx_buffer_empty_flag;
      `ADR_PERIPH_INT_ENABLES: r = s.int_en;
      `ADR_INT_CONTROL:
      begin
        r[`INTC_GIE] = s.global_int_enable;
        r[`INTC_PERIPHERAL_INT_ENABLE] = s.peripheral_int_enable;
      end
      `ADR_PIN_CONTROL:
      begin
        r[`PIN_TX_DIR] = s.pin_dir[0];
        r[`PIN_RX_DIR] = s.pin_dir[1];
        r[`PIN_TX_LATCH] = s.pin_latch[0];
        r[`PIN_RX_LATCH] = s.pin_latch[1];
        r[`PIN_TX_LEVEL] = tx_lvl;
        r[`PIN_RX_LEVEL] = rx_lvl;
      end
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  function automatic tx_state_t engine_reset(input tx_state_t s);
    tx_state_t t;
    t = s;
    t.phase = TX_IDLE;
    t.buf_full = 1'b0;
    t.shifter = '1;
    t.bits_left = 4'h0;
    t.pre_cnt = 6'h00;
    t.baud_cnt = 8'h00;
    t.shift_empty_status = 1'b1;
    return t;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  tx_state_t state_reg;
  tx_state_t state_next;
  bus_req_t req;
  logic access;
  logic wr;
  logic enabled;
  logic baud_tick;
  logic [5:0] pre_max;

  assign req = '{adr: wb_adr_in, we: wb_we_in, sel0: wb_sel_in[0], dat: wb_dat_in[7:0]};
  // one wait state: ack follows the request by one edge, then drops
  assign access = wb_cyc_in & wb_stb_in & ~state_reg.ack;
  assign wr = access & req.we & req.sel0;
  assign enabled = state_reg.transmit_enable_bit & ~state_reg.sync & state_reg.rx_status_control_ctl[4];
  assign pre_max = state_reg.high_baud_select ? 6'(`BAUD_PRESCALE_HIGH - 1) : 6'(`BAUD_PRESCALE_LOW - 1);
  assign baud_tick = (state_reg.pre_cnt == pre_max) &&
                     (state_reg.baud_cnt == state_reg.divisor);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    state_next.ack = 1'b0;

    // register access
    if (access)
    begin
      state_next.ack = 1'b1;
      state_next.rdata = req.we ? 8'h00 : read_mux(state_reg, req.adr, tx_pin_in, rx_pin_in);
    end
    if (wr)
    begin
      unique case (req.adr)
        `ADR_TX_STATUS_CONTROL:
        begin
          // shift_empty_status is status only; writes to it are dropped
          state_next.csrc = req.dat[`TX_STATUS_CONTROL_CSRC];
          state_next.nine_sel = req.dat[`TX_STATUS_CONTROL_NINE_SEL];
          state_next.transmit_enable_bit = req.dat[`TX_STATUS_CONTROL_TRANSMIT_ENABLE_BIT];
          state_next.sync = req.dat[`TX_STATUS_CONTROL_SYNC];
          state_next.high_baud_select = req.dat[`TX_STATUS_CONTROL_HIGH_BAUD_SELECT];
          state_next.ninth = req.dat[`TX_STATUS_CONTROL_NINTH];
        end
        `ADR_RX_STATUS_CONTROL: state_next.rx_status_control_ctl = req.dat[7:`RX_STATUS_CONTROL_CTL_LSB];
        `ADR_BAUD_DIVISOR: state_next.divisor = req.dat;
        `ADR_PERIPH_INT_ENABLES: state_next.int_en = req.dat;
        `ADR_INT_CONTROL:
        begin
          state_next.global_int_enable = req.dat[`INTC_GIE];
          state_next.peripheral_int_enable = req.dat[`INTC_PERIPHERAL_INT_ENABLE];
        end
        `ADR_PIN_CONTROL:
        begin
          state_next.pin_dir = {req.dat[`PIN_RX_DIR], req.dat[`PIN_TX_DIR]};
          state_next.pin_latch = {req.dat[`PIN_RX_LATCH], req.dat[`PIN_TX_LATCH]};
        end
        // flag register is read only; the empty flag ignores writes
        default: state_next.tx_buffer_empty_flag = state_reg.tx_buffer_empty_flag;
      endcase
    end

    // transmit engine
    if (!state_reg.rx_status_control_ctl[4])
    begin
      state_next = engine_reset(state_next);
    end
    else if (!enabled)
    begin
      state_next = engine_reset(state_next);
    end
    else
    begin
      unique case (state_reg.phase)
        TX_IDLE:
        begin
          state_next.shifter = '1;
          if (state_reg.buf_full)
          begin
            // no parity stage: the ninth bit goes out as given
            state_next.shifter = {1'b1, state_reg.nine_sel ? state_reg.buf_ninth : 1'b1,
                                  state_reg.buf_data, 1'b0};
            state_next.bits_left = state_reg.nine_sel ? `FRAME_BITS_9 : `FRAME_BITS_8;
            state_next.buf_full = 1'b0;
            state_next.shift_empty_status = 1'b0;
            state_next.pre_cnt = 6'h00;
            state_next.baud_cnt = 8'h00;
            state_next.phase = TX_SHIFT;
          end
        end
        TX_SHIFT:
        begin
          if (state_reg.pre_cnt == pre_max)
          begin
            state_next.pre_cnt = 6'h00;
            state_next.baud_cnt = baud_tick ? 8'h00 : state_reg.baud_cnt + 8'h01;
          end
          else
          begin
            state_next.pre_cnt = state_reg.pre_cnt + 6'h01;
          end
          if (baud_tick)
          begin
            state_next.shifter = {1'b1, state_reg.shifter[10:1]};
            state_next.bits_left = state_reg.bits_left - 4'h1;
            if (state_reg.bits_left == 4'h1)
            begin
              // single stop bit done; a queued character starts on this same edge
              state_next.pre_cnt = 6'h00;
              state_next.baud_cnt = 8'h00;
              if (state_reg.buf_full)
              begin
                state_next.shifter = {1'b1, state_reg.nine_sel ? state_reg.buf_ninth : 1'b1,
                                      state_reg.buf_data, 1'b0};
                state_next.bits_left = state_reg.nine_sel ? `FRAME_BITS_9 : `FRAME_BITS_8;
                state_next.buf_full = 1'b0;
              end
              else
              begin
                state_next.phase = TX_IDLE;
                state_next.shift_empty_status = 1'b1;
              end
            end
          end
        end
      endcase
    end

    // buffer write after the engine so a same-edge load never loses the new byte
    if (wr && req.adr == `ADR_TX_DATA_BUFFER && state_reg.rx_status_control_ctl[4])
    begin
      state_next.buf_data = req.dat;
      state_next.buf_ninth = state_reg.ninth;
      state_next.buf_full = enabled;
    end

    // no lag: the flag follows the buffer on the write edge, well inside the settling allowance
    state_next.tx_buffer_empty_flag = enabled & ~state_next.buf_full;
    state_next.irq = state_next.tx_buffer_empty_flag & state_reg.int_en[`PIE_TX_BUFFER_INT_ENABLE] &
                     state_reg.peripheral_int_enable & state_reg.global_int_enable;

    // pins: port enable takes both pins away from the port latch
    if (state_next.rx_status_control_ctl[4])
    begin
      state_next.tx_oe = 1'b1;
      state_next.tx_out = state_next.phase == TX_SHIFT ? state_next.shifter[0] : 1'b1;
      state_next.rx_oe = 1'b0;
      state_next.rx_out = 1'b0;
    end
    else
    begin
      state_next.tx_oe = ~state_next.pin_dir[0];
      state_next.tx_out = state_next.pin_latch[0];
      state_next.rx_oe = ~state_next.pin_dir[1];
      state_next.rx_out = state_next.pin_latch[1];
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= '{
        csrc: 1'(`TX_STATUS_CONTROL_RESET >> `TX_STATUS_CONTROL_CSRC),
        nine_sel: 1'b0,
        transmit_enable_bit: 1'b0,
        sync: 1'b0,
        high_baud_select: 1'b0,
        ninth: 1'b0,
        rx_status_control_ctl: `RX_STATUS_CONTROL_CTL_RESET,
        divisor: `BAUD_DIVISOR_RESET,
        int_en: `PIE_RESET,
        global_int_enable: 1'b0,
        peripheral_int_enable: 1'b0,
        pin_dir: `PIN_DIR_RESET,
        pin_latch: `PIN_LATCH_RESET,
        phase: TX_IDLE,
        buf_data: `TX_DATA_RESET,
        buf_ninth: 1'b0,
        buf_full: 1'b0,
        shifter: 11'h7FF,
        bits_left: 4'h0,
        pre_cnt: 6'h00,
        baud_cnt: 8'h00,
        tx_buffer_empty_flag: 1'b0,
        shift_empty_status: 1'b1,
        irq: 1'b0,
        tx_out: 1'b0,
        tx_oe: 1'b0,
        rx_out: 1'b0,
        rx_oe: 1'b0,
        ack: 1'b0,
        rdata: 8'h00
      };
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_out = {24'h000000, state_reg.rdata};
  assign wb_ack_out = state_reg.ack;
  assign tx_pin_out = state_reg.tx_out;
  assign tx_pin_oe_out = state_reg.tx_oe;
  assign rx_pin_out = state_reg.rx_out;
  assign rx_pin_oe_out = state_reg.rx_oe;
  assign tx_int_req_out = state_reg.irq;

endmodule // async_serial_transmitter

`default_nettype wire

// ==== src/async_tx_defines.svh ====
// register map, field positions, reset values and timing counts of the serial transmitter
// ****************************************************************
// Functional notes
// - frame is start bit at space, eight or nine data bits, then stop
// - idle line rests at mark; equal bits hold the level between them
// - data bits leave least significant bit first
// - each bit lasts one baud period from an 8-bit rate generator
// - transmitter has its own format and rate; no hardware parity bit
// - sending needs transmit enable one, sync mode zero, port enable one
// - port enable makes the transmit pin a driven serial output
// - port enable forces receive pin to input, still readable, latch not driven
// - setting transmit enable sets the buffer empty flag
// - buffer write starts sending; idle shifter takes the character at once
// - busy shifter: character waits, moves within one cycle after stop ends
// - shifting starts right after a load, no gap between characters
// - empty flag set when enabled and buffer holds nothing
// - empty flag settles by the second cycle after a buffer write
// - empty flag is read only; writes neither set nor clear it
// - flag ignores its enable; request needs flag and all three enables
// - read-only shift empty bit clears on load, sets when all bits out
// - nine-bit mode sends the held ninth bit as most significant data bit
// - software writes ninth bit first; buffer write moves all nine bits
// - set ninth bit marks the low byte as an address
// - clearing port enable returns the unit state and flags to reset
// ****************************************************************
`ifndef ASYNC_TX_DEFINES_SVH
`define ASYNC_TX_DEFINES_SVH

// ****************************************************************
// byte addresses on the register bus
// ****************************************************************
`define ADR_TX_STATUS_CONTROL 8'h00
`define ADR_RX_STATUS_CONTROL 8'h04
`define ADR_BAUD_DIVISOR 8'h08
`define ADR_TX_DATA_BUFFER 8'h0C
`define ADR_PERIPH_INT_FLAGS 8'h10
`define ADR_PERIPH_INT_ENABLES 8'h14
`define ADR_INT_CONTROL 8'h18
`define ADR_PIN_CONTROL 8'h1C

// ****************************************************************
// field positions
// ****************************************************************
`define TX_STATUS_CONTROL_CSRC 7
`define TX_STATUS_CONTROL_NINE_SEL 6
`define TX_STATUS_CONTROL_TRANSMIT_ENABLE_BIT 5
`define TX_STATUS_CONTROL_SYNC 4
`define TX_STATUS_CONTROL_HIGH_BAUD_SELECT 2
`define TX_STATUS_CONTROL_SHIFT_EMPTY_STATUS 1
`define TX_STATUS_CONTROL_NINTH 0
`define RX_STATUS_CONTROL_SERIAL_PORT_ENABLE 7
`define RX_STATUS_CONTROL_CTL_LSB 3
`define PIR_TX_BUFFER_EMPTY_FLAG 4
`define PIE_TX_BUFFER_INT_ENABLE 4
`define INTC_GIE 7
`define INTC_PERIPHERAL_INT_ENABLE 6
`define PIN_TX_DIR 0
`define PIN_RX_DIR 1
`define PIN_TX_LATCH 2
`define PIN_RX_LATCH 3
`define PIN_TX_LEVEL 4
`define PIN_RX_LEVEL 5

// ****************************************************************
// reset values
// ****************************************************************
`define TX_STATUS_CONTROL_RESET 8'h02
`define RX_STATUS_CONTROL_CTL_RESET 5'h00
`define BAUD_DIVISOR_RESET 8'h00
`define TX_DATA_RESET 8'h00
`define PIE_RESET 8'h00
`define INTC_RESET 2'h0
`define PIN_DIR_RESET 2'h3
`define PIN_LATCH_RESET 2'h0

// ****************************************************************
// timing
// ****************************************************************
`define BAUD_PRESCALE_LOW 64
`define BAUD_PRESCALE_HIGH 16
`define FRAME_BITS_8 4'hA
`define FRAME_BITS_9 4'hB

`endif

// ==== src/async_tx_pkg.sv ====
// types shared by the serial transmitter
package async_tx_pkg;

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_phase_t;

  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic sel0;
    logic [7:0] dat;
  } bus_req_t;

  typedef struct packed {
    // configuration
    logic csrc;
    logic nine_sel;
    logic transmit_enable_bit;
    logic sync;
    logic high_baud_select;
    logic ninth;
    logic [4:0] rx_status_control_ctl;
    logic [7:0] divisor;
    logic [7:0] int_en;
    logic global_int_enable;
    logic peripheral_int_enable;
    logic [1:0] pin_dir;
    logic [1:0] pin_latch;
    // transmit engine
    tx_phase_t phase;
    logic [7:0] buf_data;
    logic buf_ninth;
    logic buf_full;
    logic [10:0] shifter;
    logic [3:0] bits_left;
    logic [5:0] pre_cnt;
    logic [7:0] baud_cnt;
    logic tx_buffer_empty_flag;
    logic shift_empty_status;
    logic irq;
    // pins
    logic tx_out;
    logic tx_oe;
    logic rx_out;
    logic rx_oe;
    // bus answer
    logic ack;
    logic [7:0] rdata;
  } tx_state_t;

endpackage

// ==== sim/async_tx_props.sv ====
// port checker for the serial transmitter, bound to its top module
`timescale 1ns/10ps
`default_nettype none
`include "async_tx_defines.svh"
module async_tx_props
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // wishbone
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  // pins and request
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe_out,
  input wire logic rx_pin_out,
  input wire logic rx_pin_oe_out,
  input wire logic tx_int_req_out
);
  // ****************************************************************
  // shadow of the registers that steer pins and the request
  // ****************************************************************
  logic [7:0] rc_q;
  logic [7:0] ie_q;
  logic [7:0] ic_q;
  logic [7:0] pc_q;
  logic all_en;
  assign all_en = ie_q[4] && ic_q[7] && ic_q[6];
  // shadow takes a write on the edge the design takes it, the edge its pins update
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rc_q <= 8'h00;
      ie_q <= 8'h00;
      ic_q <= 8'h00;
      pc_q <= 8'h03;
    end
    else if (wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in[0])
    begin
      if (wb_adr_in == `ADR_RX_STATUS_CONTROL)
        rc_q <= wb_dat_in[7:0];
      if (wb_adr_in == `ADR_PERIPH_INT_ENABLES)
        ie_q <= wb_dat_in[7:0];
      if (wb_adr_in == `ADR_INT_CONTROL)
        ic_q <= wb_dat_in[7:0];
      if (wb_adr_in == `ADR_PIN_CONTROL)
        pc_q <= wb_dat_in[7:0];
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  AST_ACK_ONE:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE:
    assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_UPPER_ZERO:
    assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
  AST_TX_PIN_OWNED:
    assert property (rc_q[7] |-> tx_pin_oe_out)
    else $error("transmit pin not driven while port enabled");
  AST_RX_PIN_INPUT:
    assert property (rc_q[7] |-> !rx_pin_oe_out)
    else $error("receive pin driven while port enabled");
  AST_PORT_PINS:
    assert property (!rc_q[7] |-> tx_pin_oe_out == !pc_q[0] && rx_pin_oe_out == !pc_q[1]
      && rx_pin_out == pc_q[3])
    else $error("pins do not follow pin control while port disabled");
  AST_IDLE_MARK:
    assert property ($rose(rc_q[7]) |-> tx_pin_out)
    else $error("line not at mark when port enabled");
  AST_BIT_HOLD:
    assert property (rc_q[7] && $past(rc_q[7]) && $changed(tx_pin_out)
      |=> $stable(tx_pin_out) [*8])
    else $error("line level held shorter than a bit");
  AST_IRQ_GATED:
    assert property (tx_int_req_out |-> $past(all_en))
    else $error("request raised without all enables");
endmodule // async_tx_props
bind async_serial_transmitter async_tx_props props_i (.clk_in(clk_in), .rstn_in(rstn_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_in(wb_dat_in), .wb_sel_in(wb_sel_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .tx_pin_out(tx_pin_out), .tx_pin_oe_out(tx_pin_oe_out),
  .rx_pin_out(rx_pin_out), .rx_pin_oe_out(rx_pin_oe_out), .tx_int_req_out(tx_int_req_out));
`default_nettype wire

// ==== sim/line_receiver_model.sv ====
// far-end receiver model that decodes frames from the transmit line
`timescale 1ns/10ps
`default_nettype none
module line_receiver_model
#(
  parameter int BIT_CLKS = 16
)
(
  // clock and line
  input wire logic clk_in,
  input wire logic line_in,
  input wire logic nine_in
);
  logic [8:0] got_q[$];
  int start_q[$];
  int frame_err = 0;
  int cyc = 0;
  logic [8:0] sh;
  always @(posedge clk_in)
    cyc++;
  initial
  begin
    forever
    begin
      @(negedge line_in);
      start_q.push_back(cyc);
      // sample mid bit, away from the launching edge
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      if (line_in !== 1'b0)
        frame_err++;
      sh = 9'h000;
      for (int i = 0; i < (nine_in ? 9 : 8); i++)
      begin
        repeat (BIT_CLKS) @(posedge clk_in);
        sh[i] = line_in;
      end
      repeat (BIT_CLKS) @(posedge clk_in);
      if (line_in !== 1'b1)
        frame_err++;
      got_q.push_back(sh);
    end
  end
endmodule // line_receiver_model
`default_nettype wire

// ==== sim/async_serial_transmitter_bench.sv ====
// self-checking bench for the serial transmitter
`timescale 1ns/10ps
`default_nettype none
`include "async_tx_defines.svh"
module async_serial_transmitter_bench;
  logic clk_in, rstn_in, cyc, stb, we, rx_drive, nine, ack, tx_o, tx_oe, rx_o, rx_oe, irq;
  logic tx_line, rx_line;
  logic [7:0] adr, d;
  logic [31:0] wdat, rdat, rnd;
  logic [3:0] sel;
  logic [8:0] exp_q[$];
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
  logic [7:0] rv [9] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h33, 8'h00};
  // pull-up on the transmit line; the receive line takes rx_drive while nobody drives it
  assign tx_line = tx_oe ? tx_o : 1'b1;
  assign rx_line = rx_oe ? rx_o : rx_drive;
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  async_serial_transmitter dut (.clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel),
    .wb_dat_out(rdat), .wb_ack_out(ack), .tx_pin_in(tx_line), .tx_pin_out(tx_o),
    .tx_pin_oe_out(tx_oe), .rx_pin_in(rx_line), .rx_pin_out(rx_o), .rx_pin_oe_out(rx_oe),
    .tx_int_req_out(irq));
  line_receiver_model #(.BIT_CLKS(16)) rx_model (.clk_in(clk_in), .line_in(tx_line),
    .nine_in(nine));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v,
    input logic [3:0] s, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, v};
    sel <= s;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("ack", 32'h1, {31'h0, ack});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] x;
    bus(1'b1, a, v, 4'h1, x);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00, 4'h1, d);
  endtask
  // transmit_enable_bit and high speed always on; nine-bit select from the bench flag
  function automatic logic [7:0] cfg(input logic n9);
    return {1'b0, n9, 1'b1, 4'b0010, n9};
  endfunction
  task automatic send(input logic [8:0] v);
    int n;
    logic [7:0] c;
    n = 0;
    c = cfg(nine);
    do
    begin
      rd(`ADR_PERIPH_INT_FLAGS);
      n++;
    end
    while (d[4] !== 1'b1 && n < 400);
    wr(`ADR_TX_STATUS_CONTROL, {c[7:1], v[8]});
    exp_q.push_back(v);
    wr(`ADR_TX_DATA_BUFFER, v[7:0]);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (rx_model.got_q.size() < exp_q.size() && n < 4000)
    begin
      @(posedge clk_in);
      n++;
    end
    repeat (20) @(posedge clk_in);
    chk("frames", exp_q.size(), rx_model.got_q.size());
    while (exp_q.size() > 0 && rx_model.got_q.size() > 0)
      chk("char", exp_q.pop_front(), rx_model.got_q.pop_front());
    chk("framing", 0, rx_model.frame_err);
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    rstn_in = 1'b0;
    {cyc, stb, we, nine} = 4'h0;
    rx_drive = 1'b1;
    adr = 8'h00;
    wdat = 32'h00000000;
    sel = 4'h0;
    rnd = $urandom(357);
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk("reset value", rv[i], d);
    end
    rnd = $urandom;
    // transmit latch kept high so the far end never sees a false start
    wr(`ADR_PIN_CONTROL, {4'h0, rnd[3], 1'b1, rnd[1:0]});
    // receive pin as driven output high, so takeover must release it
    wr(`ADR_PIN_CONTROL, 8'h0C);
    rx_drive <= 1'b0;
    bus(1'b1, `ADR_BAUD_DIVISOR, 8'h5A, 4'h0, d);
    rd(`ADR_BAUD_DIVISOR);
    chk("lane gated write", 8'h00, d);
    wr(`ADR_RX_STATUS_CONTROL, 8'h80);
    rd(`ADR_PIN_CONTROL);
    chk("rx level", 1'b0, d[5]);
    rd(`ADR_PERIPH_INT_FLAGS);
    chk("flag without transmit_enable_bit", 8'h00, d);
    wr(`ADR_TX_STATUS_CONTROL, cfg(1'b0));
    rd(`ADR_PERIPH_INT_FLAGS);
    chk("flag on transmit_enable_bit", 8'h10, d);
    rd(`ADR_TX_STATUS_CONTROL);
    chk("status idle", 8'h26, d);
    wr(`ADR_PERIPH_INT_FLAGS, 8'h00);
    rd(`ADR_PERIPH_INT_FLAGS);
    chk("flag read only", 8'h10, d);
    wr(`ADR_PERIPH_INT_ENABLES, 8'h10);
    wr(`ADR_INT_CONTROL, 8'hC0);
    repeat (2) @(posedge clk_in);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(`ADR_PERIPH_INT_ENABLES, 8'h00);
    repeat (2) @(posedge clk_in);
    chk("irq off", 32'h0, {31'h0, irq});
    rnd = $urandom;
    exp_q.push_back({1'b0, rnd[7:0]});
    exp_q.push_back({1'b0, rnd[15:8]});
    wr(`ADR_TX_DATA_BUFFER, rnd[7:0]);
    wr(`ADR_TX_DATA_BUFFER, rnd[15:8]);
    rd(`ADR_PERIPH_INT_FLAGS);
    chk("flag queued", 8'h00, d);
    rd(`ADR_TX_STATUS_CONTROL);
    chk("status busy", 8'h24, d);
    drain();
    chk("gap", 160, rx_model.start_q[1] - rx_model.start_q[0]);
    rd(`ADR_PERIPH_INT_FLAGS);
    chk("flag drained", 8'h10, d);
    for (int i = 0; i < 6; i++)
    begin
      nine = (i > 2);
      rnd = $urandom;
      send({nine & (rnd[8] | (i == 3)), rnd[7:0]});
      if (i == 2)
        drain();
    end
    drain();
    wr(`ADR_TX_STATUS_CONTROL, 8'h04);
    rd(`ADR_PERIPH_INT_FLAGS);
    chk("flag transmit_enable_bit off", 8'h00, d);
    wr(`ADR_TX_DATA_BUFFER, 8'hA5);
    repeat (200) @(posedge clk_in);
    chk("no frame", 0, rx_model.got_q.size());
    wr(`ADR_TX_STATUS_CONTROL, cfg(1'b0));
    wr(`ADR_RX_STATUS_CONTROL, 8'h00);
    rd(`ADR_PERIPH_INT_FLAGS);
    chk("flag port off", 8'h00, d);
    rd(`ADR_TX_STATUS_CONTROL);
    chk("shift empty", 1'b1, d[1]);
    finish_test();
  end
endmodule // async_serial_transmitter_bench
`default_nettype wire
